// file: logic/bim_pkg.sv
package bim_pkg;

	// ****************************************************************
	// register map (APB byte addresses)
	// ****************************************************************
	localparam int          BIM_PADDR_W   = 12;
	localparam logic [11:0] BIM_OFF_CTRL  = 12'h000;
	localparam logic [11:0] BIM_OFF_STAT  = 12'h004;
	localparam logic [11:0] BIM_OFF_CNT   = 12'h008;
	localparam int          BIM_CTRL_INJ  = 0;
	localparam int          BIM_STAT_W    = 6;
	localparam int          BIM_ST_IGNT   = 0;
	localparam int          BIM_ST_IRV    = 1;
	localparam int          BIM_ST_IRCHK  = 2;
	localparam int          BIM_ST_DGNT   = 3;
	localparam int          BIM_ST_DRV    = 4;
	localparam int          BIM_ST_DRCHK  = 5;

	// ****************************************************************
	// checksum layout
	// ****************************************************************
	localparam int          BIM_BYTES     = 4;
	localparam int          BIM_BYTE_W    = 8;
	localparam int          BIM_ACHK_W    = 12;
	localparam int          BIM_RCHK_W    = 5;
	localparam int          BIM_ACHK_PM   = 4;
	localparam int          BIM_ACHK_BW   = 5;
	localparam int          BIM_ACHK_DBG  = 6;
	localparam int          BIM_ACHK_ATOP = 7;
	localparam int          BIM_ACHK_WD   = 8;
	localparam int          BIM_RCHK_ERR  = 4;
	localparam logic [11:0] BIM_INJ_MASK  = 12'h001;
	localparam logic [3:0]  BIM_INSTR_BE  = 4'hF;
	localparam logic [3:0]  BIM_WD_ZERO_P = 4'hF;
	localparam logic [5:0]  BIM_ATOP_NONE = 6'h00;
	localparam logic        BIM_EXOKAY    = 1'b0;
	localparam logic        BIM_REQPAR_ID = 1'b1;

	// ****************************************************************
	// attribution and faults
	// ****************************************************************
	localparam int          BIM_PMA_MAX   = 16;
	localparam logic [1:0]  BIM_ADDR_PAD  = 2'h0;
	localparam logic [1:0]  BIM_SZ_HALF   = 2'h1;
	localparam logic [1:0]  BIM_SZ_WORD   = 2'h2;
	localparam logic [4:0]  BIM_EXC_INSTR = 5'h01;
	localparam logic [4:0]  BIM_EXC_LOAD  = 5'h05;
	localparam logic [4:0]  BIM_EXC_STORE = 5'h07;

	typedef struct packed {
		logic [31:0] word_addr_low;
		logic [31:0] word_addr_high;
		logic        main;
		logic        bufferable;
		logic        cacheable;
		logic        integrity;
	} bim_pma_cfg_s;

	localparam bim_pma_cfg_s BIM_PMA_CFG_NONE = '0;

endpackage

// file: logic/bim_pma.sv
`timescale 1ns/100ps

// ********************************************************************
// compile-time attribution lookup
// ********************************************************************
module bim_pma
	import bim_pkg::*;
#(
	parameter int           NUM_REGIONS       = 0,
	parameter bim_pma_cfg_s CFG [BIM_PMA_MAX] = '{default: BIM_PMA_CFG_NONE}
) (
	input  wire logic [31:0] addr_in,
	output logic             main_out,
	output logic             buf_out,
	output logic             cache_out,
	output logic             integ_out
);

	logic [BIM_PMA_MAX-1:0] hit;
	logic [33:0]            full_addr;

	// 34-bit address, top bits always zero
	assign full_addr = {BIM_ADDR_PAD, addr_in};

	// per-region range compare, unused regions never hit
	for (genvar i = 0; i < BIM_PMA_MAX; i++) begin : g_region
		assign hit[i] = (i < NUM_REGIONS) &&
			(full_addr >= {CFG[i].word_addr_low, BIM_ADDR_PAD}) &&
			(full_addr < {CFG[i].word_addr_high, BIM_ADDR_PAD});
	end

	// defaults, then lowest hitting index wins
	always_comb begin
		main_out  = (NUM_REGIONS == 0);
		buf_out   = 1'b0;
		cache_out = 1'b0;
		integ_out = 1'b0;
		for (int i = BIM_PMA_MAX - 1; i >= 0; i--) begin
			if (hit[i]) begin
				main_out  = CFG[i].main;
				buf_out   = CFG[i].bufferable;
				cache_out = CFG[i].cacheable;
				integ_out = CFG[i].integrity;
			end
		end
	end

endmodule

// file: logic/bim_top.sv
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps

module bim_top
	import bim_pkg::*;
#(
	parameter int           PMA_NUM_REGIONS       = 0,
	parameter bim_pma_cfg_s PMA_CFG [BIM_PMA_MAX] = '{default: BIM_PMA_CFG_NONE}
) (
	input  wire logic                   CLK_IN,
	input  wire logic                   RST_N_IN,
	input  wire logic                   PSEL_IN,
	input  wire logic                   PENABLE_IN,
	input  wire logic                   PWRITE_IN,
	input  wire logic [BIM_PADDR_W-1:0] PADDR_IN,
	input  wire logic [31:0]            PWDATA_IN,
	output logic      [31:0]            PRDATA_OUT,
	output logic                        PREADY_OUT,
	output logic                        PSLVERR_OUT,
	input  wire logic                   IF_REQ_IN,
	input  wire logic [31:0]            IF_ADDR_IN,
	input  wire logic [2:0]             IF_PROT_IN,
	input  wire logic                   IF_DBG_IN,
	output logic                        IF_READY_OUT,
	output logic                        IF_FAULT_OUT,
	output logic      [4:0]             IF_EXC_CODE_OUT,
	output logic                        INSTR_REQ_OUT,
	output logic                        INSTR_REQPAR_OUT,
	output logic      [31:0]            INSTR_ADDR_OUT,
	output logic      [2:0]             INSTR_PROT_OUT,
	output logic      [1:0]             INSTR_MEMTYPE_OUT,
	output logic                        INSTR_DBG_OUT,
	output logic      [BIM_ACHK_W-1:0]  INSTR_ACHK_OUT,
	input  wire logic                   INSTR_GNT_IN,
	input  wire logic                   INSTR_GNTPAR_IN,
	input  wire logic                   INSTR_RVALID_IN,
	input  wire logic                   INSTR_RVALIDPAR_IN,
	input  wire logic [31:0]            INSTR_RDATA_IN,
	input  wire logic                   INSTR_ERR_IN,
	input  wire logic [BIM_RCHK_W-1:0]  INSTR_RCHK_IN,
	input  wire logic                   LS_REQ_IN,
	input  wire logic [31:0]            LS_ADDR_IN,
	input  wire logic                   LS_WE_IN,
	input  wire logic [3:0]             LS_BE_IN,
	input  wire logic [31:0]            LS_WDATA_IN,
	input  wire logic [1:0]             LS_SIZE_IN,
	input  wire logic [5:0]             LS_ATOP_IN,
	input  wire logic                   LS_SPEC_IN,
	input  wire logic [2:0]             LS_PROT_IN,
	input  wire logic                   LS_DBG_IN,
	output logic                        LS_READY_OUT,
	output logic                        LS_FAULT_OUT,
	output logic      [4:0]             LS_EXC_CODE_OUT,
	output logic                        LS_SPEC_HOLD_OUT,
	output logic                        DATA_REQ_OUT,
	output logic                        DATA_REQPAR_OUT,
	output logic      [31:0]            DATA_ADDR_OUT,
	output logic                        DATA_WE_OUT,
	output logic      [3:0]             DATA_BE_OUT,
	output logic      [31:0]            DATA_WDATA_OUT,
	output logic      [5:0]             DATA_ATOP_OUT,
	output logic      [2:0]             DATA_PROT_OUT,
	output logic      [1:0]             DATA_MEMTYPE_OUT,
	output logic                        DATA_DBG_OUT,
	output logic                        DATA_WBUF_OUT,
	output logic      [BIM_ACHK_W-1:0]  DATA_ACHK_OUT,
	input  wire logic                   DATA_GNT_IN,
	input  wire logic                   DATA_GNTPAR_IN,
	input  wire logic                   DATA_RVALID_IN,
	input  wire logic                   DATA_RVALIDPAR_IN,
	input  wire logic [31:0]            DATA_RDATA_IN,
	input  wire logic                   DATA_ERR_IN,
	input  wire logic [BIM_RCHK_W-1:0]  DATA_RCHK_IN,
	output logic                        ALERT_MAJOR_OUT
);

	// ****************************************************************
	// checksum helpers
	// ****************************************************************

	// address phase checksum, odd parity per group
	function automatic logic [BIM_ACHK_W-1:0] achk_f(
		input logic [31:0] a,
		input logic [2:0]  p,
		input logic [1:0]  mt,
		input logic [3:0]  be,
		input logic        we,
		input logic        dbg,
		input logic [5:0]  at,
		input logic [31:0] wd
	);
		logic [BIM_ACHK_W-1:0] c;
		c = '0;
		for (int b = 0; b < BIM_BYTES; b++) begin
			c[b]               = ~^a[b*BIM_BYTE_W +: BIM_BYTE_W];
			c[b + BIM_ACHK_WD] = ~^wd[b*BIM_BYTE_W +: BIM_BYTE_W];
		end
		c[BIM_ACHK_PM]   = ~^{p, mt};
		c[BIM_ACHK_BW]   = ~^{be, we};
		c[BIM_ACHK_DBG]  = ~dbg;
		c[BIM_ACHK_ATOP] = ~^at;
		return c;
	endfunction

	// expected response checksum, exokay fixed low
	function automatic logic [BIM_RCHK_W-1:0] rchk_f(input logic [31:0] d, input logic e);
		logic [BIM_RCHK_W-1:0] c;
		c = '0;
		for (int b = 0; b < BIM_BYTES; b++) begin
			c[b] = ~^d[b*BIM_BYTE_W +: BIM_BYTE_W];
		end
		c[BIM_RCHK_ERR] = ~^{e, BIM_EXOKAY};
		return c;
	endfunction

	// ****************************************************************
	// attribution lookup and request decode
	// ****************************************************************
	logic                   if_main, if_buf, if_cache, if_integ;
	logic                   ls_main, ls_buf, ls_cache, ls_integ;
	logic                   take_if, take_ls, ls_misal, ls_fault, ls_go, ls_bst;
	logic                   if_pend_q, if_integ_q, ls_pend_q, ls_integ_q, ls_rd_q;
	logic                   ctrl_inj_q;
	logic [BIM_ACHK_W-1:0]  inj_mask;
	logic [BIM_STAT_W-1:0]  st_set, st_q, st_clr;
	logic [31:0]            cnt_q;
	logic                   par_err, apb_setup, apb_wr;

	bim_pma #(
		.NUM_REGIONS (PMA_NUM_REGIONS),
		.CFG         (PMA_CFG)
	) u_pma_if (
		.addr_in   (IF_ADDR_IN),
		.main_out  (if_main),
		.buf_out   (if_buf),
		.cache_out (if_cache),
		.integ_out (if_integ)
	);

	bim_pma #(
		.NUM_REGIONS (PMA_NUM_REGIONS),
		.CFG         (PMA_CFG)
	) u_pma_ls (
		.addr_in   (LS_ADDR_IN),
		.main_out  (ls_main),
		.buf_out   (ls_buf),
		.cache_out (ls_cache),
		.integ_out (ls_integ)
	);

	// request acceptance and attribute checks
	assign take_if  = IF_REQ_IN && IF_READY_OUT;
	assign take_ls  = LS_REQ_IN && LS_READY_OUT;
	assign ls_misal = ((LS_SIZE_IN == BIM_SZ_HALF) && LS_ADDR_IN[0]) ||
		((LS_SIZE_IN == BIM_SZ_WORD) && (LS_ADDR_IN[1:0] != BIM_ADDR_PAD));
	assign ls_fault = take_ls && !ls_main && ls_misal;
	assign ls_go    = take_ls && !ls_fault && (ls_main || !LS_SPEC_IN);
	assign ls_bst   = ls_buf && LS_WE_IN && (LS_ATOP_IN == BIM_ATOP_NONE);
	assign inj_mask = {BIM_ACHK_W{ctrl_inj_q}} & BIM_INJ_MASK;

	// ****************************************************************
	// instruction port
	// ****************************************************************

	// fetch request stage, I/O fetches never reach the bus
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			INSTR_REQ_OUT     <= 1'b0;
			INSTR_REQPAR_OUT  <= BIM_REQPAR_ID;
			INSTR_ADDR_OUT    <= '0;
			INSTR_PROT_OUT    <= '0;
			INSTR_MEMTYPE_OUT <= '0;
			INSTR_DBG_OUT     <= 1'b0;
			INSTR_ACHK_OUT    <= '0;
			if_integ_q        <= 1'b0;
		end else if (take_if && if_main) begin
			INSTR_REQ_OUT     <= 1'b1;
			INSTR_REQPAR_OUT  <= 1'b0;
			INSTR_ADDR_OUT    <= IF_ADDR_IN;
			INSTR_PROT_OUT    <= IF_PROT_IN;
			INSTR_MEMTYPE_OUT <= {if_cache, 1'b0};
			INSTR_DBG_OUT     <= IF_DBG_IN;
			INSTR_ACHK_OUT    <= achk_f(IF_ADDR_IN, IF_PROT_IN, {if_cache, 1'b0},
				BIM_INSTR_BE, 1'b0, IF_DBG_IN, BIM_ATOP_NONE, '0) ^ inj_mask;
			if_integ_q        <= if_integ;
		end else if (INSTR_REQ_OUT && INSTR_GNT_IN) begin
			INSTR_REQ_OUT     <= 1'b0;
			INSTR_REQPAR_OUT  <= BIM_REQPAR_ID;
		end
	end

	// fetch response tracking and ready
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			if_pend_q    <= 1'b0;
			IF_READY_OUT <= 1'b1;
		end else begin
			if (INSTR_REQ_OUT && INSTR_GNT_IN) begin
				if_pend_q <= 1'b1;
			end else if (INSTR_RVALID_IN) begin
				if_pend_q <= 1'b0;
			end
			if (take_if && if_main) begin
				IF_READY_OUT <= 1'b0;
			end else if (if_pend_q && INSTR_RVALID_IN) begin
				IF_READY_OUT <= 1'b1;
			end
		end
	end

	// fetch access fault pulse
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			IF_FAULT_OUT    <= 1'b0;
			IF_EXC_CODE_OUT <= '0;
		end else begin
			IF_FAULT_OUT    <= take_if && !if_main;
			IF_EXC_CODE_OUT <= (take_if && !if_main) ? BIM_EXC_INSTR : '0;
		end
	end

	// ****************************************************************
	// data port
	// ****************************************************************

	// load/store request stage
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			DATA_REQ_OUT     <= 1'b0;
			DATA_REQPAR_OUT  <= BIM_REQPAR_ID;
			DATA_ADDR_OUT    <= '0;
			DATA_WE_OUT      <= 1'b0;
			DATA_BE_OUT      <= '0;
			DATA_WDATA_OUT   <= '0;
			DATA_ATOP_OUT    <= '0;
			DATA_PROT_OUT    <= '0;
			DATA_MEMTYPE_OUT <= '0;
			DATA_DBG_OUT     <= 1'b0;
			DATA_WBUF_OUT    <= 1'b0;
			DATA_ACHK_OUT    <= '0;
			ls_integ_q       <= 1'b0;
			ls_rd_q          <= 1'b0;
		end else if (ls_go) begin
			DATA_REQ_OUT     <= 1'b1;
			DATA_REQPAR_OUT  <= 1'b0;
			DATA_ADDR_OUT    <= LS_ADDR_IN;
			DATA_WE_OUT      <= LS_WE_IN;
			DATA_BE_OUT      <= LS_BE_IN;
			DATA_WDATA_OUT   <= LS_WDATA_IN;
			DATA_ATOP_OUT    <= LS_ATOP_IN;
			DATA_PROT_OUT    <= LS_PROT_IN;
			DATA_MEMTYPE_OUT <= {ls_cache, ls_bst};
			DATA_DBG_OUT     <= LS_DBG_IN;
			DATA_WBUF_OUT    <= ls_bst;
			DATA_ACHK_OUT    <= achk_f(LS_ADDR_IN, LS_PROT_IN, {ls_cache, ls_bst}, LS_BE_IN,
				LS_WE_IN, LS_DBG_IN, LS_ATOP_IN, LS_WDATA_IN) ^ inj_mask;
			ls_integ_q       <= ls_integ;
			ls_rd_q          <= !LS_WE_IN;
		end else if (DATA_REQ_OUT && DATA_GNT_IN) begin
			DATA_REQ_OUT     <= 1'b0;
			DATA_REQPAR_OUT  <= BIM_REQPAR_ID;
		end
	end

	// load/store response tracking and ready
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ls_pend_q    <= 1'b0;
			LS_READY_OUT <= 1'b1;
		end else begin
			if (DATA_REQ_OUT && DATA_GNT_IN) begin
				ls_pend_q <= 1'b1;
			end else if (DATA_RVALID_IN) begin
				ls_pend_q <= 1'b0;
			end
			if (ls_go) begin
				LS_READY_OUT <= 1'b0;
			end else if (ls_pend_q && DATA_RVALID_IN) begin
				LS_READY_OUT <= 1'b1;
			end
		end
	end

	// access fault and speculation hold pulses
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			LS_FAULT_OUT     <= 1'b0;
			LS_EXC_CODE_OUT  <= '0;
			LS_SPEC_HOLD_OUT <= 1'b0;
		end else begin
			LS_FAULT_OUT     <= ls_fault;
			LS_EXC_CODE_OUT  <= !ls_fault ? '0 : (LS_WE_IN ? BIM_EXC_STORE : BIM_EXC_LOAD);
			LS_SPEC_HOLD_OUT <= take_ls && !ls_fault && !ls_go;
		end
	end

	// ****************************************************************
	// integrity checks and alert
	// ****************************************************************

	// handshake parity always, checksum only for integrity regions
	assign st_set[BIM_ST_IGNT]  = (INSTR_GNTPAR_IN == INSTR_GNT_IN);
	assign st_set[BIM_ST_IRV]   = (INSTR_RVALIDPAR_IN == INSTR_RVALID_IN);
	assign st_set[BIM_ST_DGNT]  = (DATA_GNTPAR_IN == DATA_GNT_IN);
	assign st_set[BIM_ST_DRV]   = (DATA_RVALIDPAR_IN == DATA_RVALID_IN);
	assign st_set[BIM_ST_IRCHK] = if_pend_q && INSTR_RVALID_IN && if_integ_q &&
		(INSTR_RCHK_IN != rchk_f(INSTR_RDATA_IN, INSTR_ERR_IN));
	assign st_set[BIM_ST_DRCHK] = ls_pend_q && DATA_RVALID_IN && ls_integ_q &&
		(ls_rd_q ? (DATA_RCHK_IN != rchk_f(DATA_RDATA_IN, DATA_ERR_IN)) :
		(DATA_RCHK_IN[BIM_RCHK_ERR] != ~^{DATA_ERR_IN, BIM_EXOKAY}));
	assign par_err = st_set[BIM_ST_IGNT] || st_set[BIM_ST_IRV] ||
		st_set[BIM_ST_DGNT] || st_set[BIM_ST_DRV];

	// alert high one cycle per mismatch cycle, plus cycle count
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ALERT_MAJOR_OUT <= 1'b0;
			cnt_q           <= '0;
		end else begin
			ALERT_MAJOR_OUT <= |st_set;
			cnt_q           <= cnt_q + 32'(|st_set);
		end
	end

	// sticky status, a new event beats the clear
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_q <= '0;
		end else begin
			st_q <= (st_q & ~st_clr) | st_set;
		end
	end

	// ****************************************************************
	// APB slave, one wait-free access cycle
	// ****************************************************************
	assign apb_setup = PSEL_IN && !PENABLE_IN;
	assign apb_wr    = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT && !PSLVERR_OUT;
	assign st_clr    = (apb_wr && (PADDR_IN == BIM_OFF_STAT)) ? PWDATA_IN[BIM_STAT_W-1:0] : '0;

	// decode at setup, answer in the access cycle
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT  <= '0;
		end else begin
			PREADY_OUT  <= apb_setup;
			PSLVERR_OUT <= apb_setup && (PADDR_IN != BIM_OFF_CTRL) &&
				(PADDR_IN != BIM_OFF_STAT) && (PADDR_IN != BIM_OFF_CNT);
			case (PADDR_IN)
				BIM_OFF_CTRL: PRDATA_OUT <= 32'(ctrl_inj_q);
				BIM_OFF_STAT: PRDATA_OUT <= 32'(st_q);
				BIM_OFF_CNT:  PRDATA_OUT <= cnt_q;
				default:      PRDATA_OUT <= '0;
			endcase
		end
	end

	// control: checksum fault injection for checker bring-up
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_inj_q <= 1'b0;
		end else if (apb_wr && (PADDR_IN == BIM_OFF_CTRL)) begin
			ctrl_inj_q <= PWDATA_IN[BIM_CTRL_INJ];
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	AST_REQPAR:
	assert property ((INSTR_REQPAR_OUT != INSTR_REQ_OUT) && (DATA_REQPAR_OUT != DATA_REQ_OUT))
		else $error("request parity not odd");

	AST_DATA_ACHK:
	assert property (DATA_REQ_OUT && !ctrl_inj_q |-> DATA_ACHK_OUT == achk_f(DATA_ADDR_OUT,
		DATA_PROT_OUT, DATA_MEMTYPE_OUT, DATA_BE_OUT, DATA_WE_OUT, DATA_DBG_OUT,
		DATA_ATOP_OUT, DATA_WDATA_OUT))
		else $error("data checksum mismatch");

	AST_INSTR_ACHK:
	assert property (INSTR_REQ_OUT |-> INSTR_ACHK_OUT[BIM_ACHK_BW] == ~^{BIM_INSTR_BE, 1'b0} &&
		INSTR_ACHK_OUT[BIM_ACHK_W-1:BIM_ACHK_WD] == BIM_WD_ZERO_P && INSTR_ACHK_OUT[BIM_ACHK_ATOP])
		else $error("fetch checksum constants wrong");

	AST_GNT_ALERT:
	assert property ((INSTR_GNTPAR_IN == INSTR_GNT_IN) ||
		(INSTR_RVALIDPAR_IN == INSTR_RVALID_IN) || (DATA_GNTPAR_IN == DATA_GNT_IN) ||
		(DATA_RVALIDPAR_IN == DATA_RVALID_IN) |=> ALERT_MAJOR_OUT)
		else $error("parity error without alert");

	AST_UNCHECKED:
	assert property (!par_err && !if_integ_q && !ls_integ_q |=> !ALERT_MAJOR_OUT)
		else $error("alert for unchecked region");

	AST_WRITE_RDATA:
	assert property (!par_err && !if_integ_q && ls_pend_q && !ls_rd_q && DATA_RVALID_IN &&
		DATA_RCHK_IN[BIM_RCHK_ERR] == ~DATA_ERR_IN |=> !ALERT_MAJOR_OUT)
		else $error("write response data checked");

	AST_FETCH_IO:
	assert property (take_if && !if_main |=> IF_FAULT_OUT && IF_EXC_CODE_OUT == BIM_EXC_INSTR
		&& !INSTR_REQ_OUT ##1 !IF_FAULT_OUT)
		else $error("fetch from I/O not faulted");

	AST_MISALIGN:
	assert property (ls_fault |=> LS_FAULT_OUT && !DATA_REQ_OUT && LS_EXC_CODE_OUT ==
		($past(LS_WE_IN) ? BIM_EXC_STORE : BIM_EXC_LOAD))
		else $error("misaligned I/O access not faulted");

	AST_SPEC_IO:
	assert property (take_ls && LS_SPEC_IN && !ls_main |=> !DATA_REQ_OUT && LS_READY_OUT)
		else $error("speculative I/O access issued");

	AST_MAIN_MISAL:
	assert property (take_ls && ls_main |=> DATA_REQ_OUT && !LS_FAULT_OUT)
		else $error("main memory access not issued");

	AST_MEMTYPE:
	assert property (DATA_REQ_OUT && DATA_MEMTYPE_OUT[0] |-> DATA_WE_OUT && DATA_WBUF_OUT &&
		DATA_ATOP_OUT == BIM_ATOP_NONE && !INSTR_MEMTYPE_OUT[0])
		else $error("bufferable bit on wrong access");

endmodule

// file: tb/bim_obi_slave.sv
`timescale 1ns/100ps

// ****************************************************************
// bus slave: grants a request, answers on the following cycle
// ****************************************************************
module bim_obi_slave (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        req_in,
	input  wire logic        slow_in,
	input  wire logic [1:0]  bad_in,
	input  wire logic [31:0] addr_in,
	output logic             gnt_out,
	output logic             gp_out,
	output logic             rv_out,
	output logic             rvp_out,
	output logic [31:0]      rd_out,
	output logic             err_out,
	output logic [4:0]       rchk_out
);
	logic wait_q;

	// grant, one cycle late when slow; idle read data toggles
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gnt_out <= 1'b0;
			rv_out  <= 1'b0;
			rd_out  <= 32'h0;
			wait_q  <= 1'b0;
		end else begin
			wait_q  <= req_in & ~gnt_out & ~wait_q;
			gnt_out <= req_in & ~gnt_out & (~slow_in | wait_q);
			rv_out  <= gnt_out;
			rd_out  <= gnt_out ? ~addr_in : ~rd_out;
		end
	end

	// parities, bad_in breaks grant parity and rchk bit 0 on purpose
	assign err_out  = 1'b0;
	assign gp_out   = ~gnt_out ^ (bad_in[1] & gnt_out);
	assign rvp_out  = ~rv_out;
	assign rchk_out = {~err_out, ~^rd_out[31:24], ~^rd_out[23:16], ~^rd_out[15:8],
		~^rd_out[7:0] ^ bad_in[0]};
endmodule

// file: tb/bim_top_tb_top.sv
`timescale 1ns/100ps

module bim_top_tb_top;
	import bim_pkg::*;
	typedef struct packed {
		logic i; logic [31:0] a; logic w; logic [1:0] z; logic s; logic [1:0] b;
		logic q; logic [4:0] c; logic h; logic [1:0] m; logic wb; logic [1:0] al;
	} bim_row_s;
	localparam bim_pma_cfg_s CFG [BIM_PMA_MAX] = '{0: '{32'h0, 32'h400, 1, 0, 1, 1},
		1: '{32'h200, 32'h800, 0, 1, 0, 0}, 2: '{32'h800, 32'hC00, 1, 1, 0, 0},
		default: BIM_PMA_CFG_NONE};
	localparam bim_row_s ROWS [12] = '{'{1, 'h100, 0, 2, 0, 0, 1, 0, 0, 2, 0, 0},
		'{1, 'h1000, 0, 2, 0, 0, 0, 1, 0, 0, 0, 0}, '{1, 'h2000, 0, 2, 0, 0, 1, 0, 0, 0, 0, 0},
		'{0, 'h804, 0, 2, 0, 1, 1, 0, 0, 2, 0, 1}, '{0, 'h1001, 1, 1, 0, 0, 0, 7, 0, 0, 0, 0},
		'{0, 'h1001, 0, 1, 0, 0, 0, 5, 0, 0, 0, 0}, '{0, 'h1004, 1, 2, 0, 0, 1, 0, 0, 1, 1, 0},
		'{0, 'h2001, 1, 2, 0, 2, 1, 0, 0, 1, 1, 1}, '{0, 'h2004, 0, 2, 0, 1, 1, 0, 0, 0, 0, 0},
		'{0, 'h8, 1, 2, 0, 1, 1, 0, 0, 2, 0, 0}, '{0, 'h4000, 0, 2, 1, 0, 0, 0, 1, 0, 0, 0},
		'{0, 'h3001, 1, 1, 0, 0, 0, 7, 0, 0, 0, 0}};
	logic CLK_IN, RST_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT, slow;
	logic IF_REQ_IN, IF_DBG_IN, IF_READY_OUT, IF_FAULT_OUT, INSTR_REQ_OUT, INSTR_REQPAR_OUT;
	logic INSTR_DBG_OUT, INSTR_GNT_IN, INSTR_GNTPAR_IN, INSTR_RVALID_IN, INSTR_RVALIDPAR_IN;
	logic INSTR_ERR_IN, LS_REQ_IN, LS_WE_IN, LS_SPEC_IN, LS_DBG_IN, LS_READY_OUT, LS_FAULT_OUT;
	logic LS_SPEC_HOLD_OUT, DATA_REQ_OUT, DATA_REQPAR_OUT, DATA_WE_OUT, DATA_DBG_OUT, DATA_WBUF_OUT;
	logic DATA_GNT_IN, DATA_GNTPAR_IN, DATA_RVALID_IN, DATA_RVALIDPAR_IN, DATA_ERR_IN;
	logic ALERT_MAJOR_OUT;
	logic [31:0] PWDATA_IN, PRDATA_OUT, IF_ADDR_IN, INSTR_ADDR_OUT, INSTR_RDATA_IN, LS_ADDR_IN;
	logic [31:0] LS_WDATA_IN, DATA_ADDR_OUT, DATA_WDATA_OUT, DATA_RDATA_IN;
	logic [11:0] PADDR_IN, INSTR_ACHK_OUT, DATA_ACHK_OUT;
	logic [5:0]  LS_ATOP_IN, DATA_ATOP_OUT;
	logic [4:0]  IF_EXC_CODE_OUT, LS_EXC_CODE_OUT, INSTR_RCHK_IN, DATA_RCHK_IN;
	logic [3:0]  LS_BE_IN, DATA_BE_OUT;
	logic [2:0]  IF_PROT_IN, INSTR_PROT_OUT, LS_PROT_IN, DATA_PROT_OUT;
	logic [1:0]  INSTR_MEMTYPE_OUT, LS_SIZE_IN, DATA_MEMTYPE_OUT, bad;
	int          failures, cmp_count, alerts, cyc;

	bim_top #(.PMA_NUM_REGIONS(3), .PMA_CFG(CFG)) uut (.*);
	bim_obi_slave islv (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .req_in(INSTR_REQ_OUT),
		.slow_in(slow), .bad_in(2'h0), .addr_in(INSTR_ADDR_OUT), .gnt_out(INSTR_GNT_IN),
		.gp_out(INSTR_GNTPAR_IN), .rv_out(INSTR_RVALID_IN), .rvp_out(INSTR_RVALIDPAR_IN),
		.rd_out(INSTR_RDATA_IN), .err_out(INSTR_ERR_IN), .rchk_out(INSTR_RCHK_IN));
	bim_obi_slave dslv (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .req_in(DATA_REQ_OUT),
		.slow_in(slow), .bad_in(bad), .addr_in(DATA_ADDR_OUT), .gnt_out(DATA_GNT_IN),
		.gp_out(DATA_GNTPAR_IN), .rv_out(DATA_RVALID_IN), .rvp_out(DATA_RVALIDPAR_IN),
		.rd_out(DATA_RDATA_IN), .err_out(DATA_ERR_IN), .rchk_out(DATA_RCHK_IN));

	// clock, alert cycle count and hang guard
	initial begin
		CLK_IN = 1'b0;
		forever #2.5 CLK_IN = ~CLK_IN;
	end
	always @(posedge CLK_IN) begin
		alerts += (ALERT_MAJOR_OUT === 1'b1);
		cyc++;
		if (cyc == 3000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [11:0] achk(logic [31:0] a, logic [2:0] p, logic [1:0] m, logic w,
		logic d, logic [31:0] wd);
		return {~^wd[31:24], ~^wd[23:16], ~^wd[15:8], ~^wd[7:0], 1'b1, ~d, ~^{4'hF, w},
			~^{p, m}, ~^a[31:24], ~^a[23:16], ~^a[15:8], ~^a[7:0]};
	endfunction

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		input logic [32:0] exp);
		PSEL_IN <= 1'b1;
		PWRITE_IN <= w;
		PADDR_IN <= a;
		PWDATA_IN <= wd;
		@(posedge CLK_IN);
		PENABLE_IN <= 1'b1;
		do @(posedge CLK_IN); while (PREADY_OUT !== 1'b1 && cyc < 3000);
		if (!w) chk({PSLVERR_OUT, PRDATA_OUT}, exp);
		PENABLE_IN <= 1'b0;
	endtask

	// one core request, then the outputs it should give
	task automatic run(input bim_row_s r, input logic [2:0] k, input logic [11:0] inj);
		int n;
		n = alerts;
		{bad, slow, IF_REQ_IN, LS_REQ_IN} <= {r.b, k[0], r.i, !r.i};
		{IF_ADDR_IN, LS_ADDR_IN, LS_WDATA_IN, IF_PROT_IN, LS_PROT_IN} <= {r.a, r.a, ~r.a, k, k};
		{LS_WE_IN, LS_SIZE_IN, LS_SPEC_IN, LS_DBG_IN, IF_DBG_IN} <= {r.w, r.z, r.s, k[0], k[1]};
		@(posedge CLK_IN);
		{IF_REQ_IN, LS_REQ_IN} <= 2'h0;
		#1;
		chk(r.i ? INSTR_REQ_OUT : DATA_REQ_OUT, r.q);
		chk(r.i ? INSTR_REQPAR_OUT : DATA_REQPAR_OUT, !r.q);
		chk(r.i ? IF_EXC_CODE_OUT : LS_EXC_CODE_OUT, r.c);
		chk(r.i ? IF_FAULT_OUT : LS_FAULT_OUT, r.c != 5'h0);
		chk(LS_SPEC_HOLD_OUT, r.h);
		if (r.q) begin
			chk(r.i ? INSTR_MEMTYPE_OUT : DATA_MEMTYPE_OUT, r.m);
			chk(DATA_WBUF_OUT, r.wb);
			chk(r.i ? INSTR_ADDR_OUT : DATA_ADDR_OUT, r.a);
			chk(r.i ? {INSTR_PROT_OUT, INSTR_DBG_OUT} : {DATA_PROT_OUT, DATA_DBG_OUT}, {k, k[r.i]});
			if (!r.i) chk({DATA_WE_OUT, DATA_WDATA_OUT}, {r.w, ~r.a});
			if (!r.i) chk({DATA_BE_OUT, DATA_ATOP_OUT}, {4'hF, 6'h00});
			chk(r.i ? INSTR_ACHK_OUT : DATA_ACHK_OUT, inj ^ (r.i ?
				achk(r.a, k, r.m, 1'b0, k[1], 32'h0) :
				achk(r.a, k, r.m, r.w, k[0], ~r.a)));
		end
		for (int j = 0; j < 40 && !(IF_READY_OUT === 1'b1 && LS_READY_OUT === 1'b1); j++)
			@(posedge CLK_IN);
		repeat (2) @(posedge CLK_IN);
		chk(alerts - n, r.al);
	endtask

	task automatic wrap_up();
		if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// reset, row loop, then status through the register bus
	initial begin
		{RST_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN, slow, bad} = '0;
		{IF_REQ_IN, IF_ADDR_IN, IF_PROT_IN, IF_DBG_IN, LS_REQ_IN, LS_ADDR_IN, LS_WE_IN} = '0;
		{LS_WDATA_IN, LS_SIZE_IN, LS_SPEC_IN, LS_PROT_IN, LS_DBG_IN, LS_ATOP_IN} = '0;
		LS_BE_IN = 4'hF;
		repeat (8) @(posedge CLK_IN);
		chk({IF_READY_OUT, LS_READY_OUT, INSTR_REQPAR_OUT, DATA_REQPAR_OUT, ALERT_MAJOR_OUT},
			5'h1E);
		RST_N_IN <= 1'b1;
		@(posedge CLK_IN);
		foreach (ROWS[k]) run(ROWS[k], k[2:0], 12'h000);
		apb(1'b0, BIM_OFF_STAT, 32'h0, 33'h28);
		apb(1'b0, BIM_OFF_CNT, 32'h0, 33'h2);
		apb(1'b1, BIM_OFF_STAT, 32'h3F, 33'h0);
		apb(1'b0, BIM_OFF_STAT, 32'h0, 33'h0);
		apb(1'b0, 12'h00C, 32'h0, 33'h1_0000_0000);
		apb(1'b1, BIM_OFF_CTRL, 32'h1, 33'h0);
		apb(1'b0, BIM_OFF_CTRL, 32'h0, 33'h1);
		PSEL_IN <= 1'b0;
		run(ROWS[0], 3'h0, BIM_INJ_MASK);
		// reset in mid-run clears counter and control
		RST_N_IN <= 1'b0;
		@(posedge CLK_IN);
		chk({IF_READY_OUT, LS_READY_OUT, INSTR_REQPAR_OUT, DATA_REQPAR_OUT, ALERT_MAJOR_OUT},
			5'h1E);
		RST_N_IN <= 1'b1;
		@(posedge CLK_IN);
		apb(1'b0, BIM_OFF_CNT, 32'h0, 33'h0);
		apb(1'b0, BIM_OFF_CTRL, 32'h0, 33'h0);
		PSEL_IN <= 1'b0;
		wrap_up();
	end
endmodule
